// ==== pkg/tmr_consts.svh ====
// Offsets, field positions, reset values and counts of the 16-bit timer
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// Byte register offsets
`define TMR_ADDR_CTRL_A   4'h0
`define TMR_ADDR_CTRL_B   4'h1
`define TMR_ADDR_CNT_L    4'h2
`define TMR_ADDR_CNT_H    4'h3
`define TMR_ADDR_CMPA_L   4'h4
`define TMR_ADDR_CMPA_H   4'h5
`define TMR_ADDR_CMPB_L   4'h6
`define TMR_ADDR_CMPB_H   4'h7
`define TMR_ADDR_CAP_L    4'h8
`define TMR_ADDR_CAP_H    4'h9
`define TMR_ADDR_IRQ_STAT 4'hA
`define TMR_ADDR_IRQ_CLR  4'hB
`define TMR_ADDR_IRQ_EN   4'hC

// Field positions
`define TMR_ACT_A_LSB     6
`define TMR_ACT_B_LSB     4
`define TMR_WGM_LO_LSB    0
`define TMR_EDGE_BIT      6
`define TMR_SRC_BIT       5
`define TMR_WGM_HI_LSB    3
`define TMR_CS_LSB        0
`define TMR_ST_OVF        0
`define TMR_ST_CMPA       1
`define TMR_ST_CMPB       2
`define TMR_ST_CAP        3

// Reset values
`define TMR_RST_SYNC      4'h0
`define TMR_RST_STATE     '0

// Counter limits
`define TMR_BOTTOM        16'h0000
`define TMR_TOP8          16'h00FF
`define TMR_TOP9          16'h01FF
`define TMR_TOP10         16'h03FF
`define TMR_MAX           16'hFFFF

// Prescaler masks: tick when the low divider bits are all ones
`define TMR_DIV_M1        10'h000
`define TMR_DIV_M8        10'h007
`define TMR_DIV_M64       10'h03F
`define TMR_DIV_M256      10'h0FF
`define TMR_DIV_M1024     10'h3FF

`endif

// ==== pkg/tmr_pkg.sv ====
// Types of the 16-bit timer with capture and PWM
`default_nettype none
package tmr_pkg;

  typedef enum logic [3:0] {
    TMR_M_NORMAL = 4'h0,
    TMR_M_PC8    = 4'h1,
    TMR_M_PC9    = 4'h2,
    TMR_M_PC10   = 4'h3,
    TMR_M_CTC_A  = 4'h4,
    TMR_M_FAST8  = 4'h5,
    TMR_M_FAST9  = 4'h6,
    TMR_M_FAST10 = 4'h7,
    TMR_M_PFC_C  = 4'h8,
    TMR_M_PFC_A  = 4'h9,
    TMR_M_PC_C   = 4'hA,
    TMR_M_PC_A   = 4'hB,
    TMR_M_CTC_C  = 4'hC,
    TMR_M_RSVD   = 4'hD,
    TMR_M_FAST_C = 4'hE,
    TMR_M_FAST_A = 4'hF
  } tmr_mode_e;

  typedef enum logic [2:0] {
    TMR_CS_STOP    = 3'h0,
    TMR_CS_DIV1    = 3'h1,
    TMR_CS_DIV8    = 3'h2,
    TMR_CS_DIV64   = 3'h3,
    TMR_CS_DIV256  = 3'h4,
    TMR_CS_DIV1024 = 3'h5,
    TMR_CS_RSV6    = 3'h6,
    TMR_CS_RSV7    = 3'h7
  } tmr_clk_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr_bus_s;

  typedef struct packed {
    logic [2:0] ff;
    logic       lvl;
  } tmr_sync_s;

  typedef struct packed {
    tmr_mode_e   mode;
    logic [1:0]  act_a;
    logic [1:0]  act_b;
    logic        edge_rise;
    logic        src_cmp;
    tmr_clk_e    clk_sel;
    logic [15:0] cnt;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpa;
    logic [15:0] cmpb_buf;
    logic [15:0] cmpb;
    logic [15:0] cap;
    logic [7:0]  temp;
    logic [9:0]  div;
    logic        down;
    logic        lvl_prev;
    logic [3:0]  stat;
    logic [3:0]  en;
    logic        irq;
    logic        out_a;
    logic        out_b;
    logic        oe_a;
    logic        oe_b;
    logic [7:0]  rdata;
  } tmr_state_s;

endpackage : tmr_pkg
`default_nettype wire

// ==== src/tmr_core.sv ====
// 16-bit timer with input capture, fast and phase-correct PWM
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"

module tmr_core (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire tmr_pkg::tmr_bus_s bus,
  output logic [7:0]             rdata,
  input  wire logic              capture_pin,
  input  wire logic              comparator_output,
  input  wire logic              capture_ack,
  output logic                   irq,
  output logic                   wave_out_a,
  output logic                   wave_oe_a,
  output logic                   wave_out_b,
  output logic                   wave_oe_b
);

  tmr_pkg::tmr_state_s s_reg;
  tmr_pkg::tmr_state_s s_next;

  logic        pin_lvl;
  logic        cmp_lvl;
  logic        src_lvl;
  logic        cap_event;
  logic        is_fast;
  logic        is_pc;
  logic        is_pfc;
  logic        buffered;
  logic        cap_top;
  logic        tog_a_ok;
  logic [15:0] top_val;
  logic [15:0] fix_mask;
  logic [9:0]  div_mask;
  logic        tick;
  logic        at_top;
  logic        at_bot;
  logic        match_a;
  logic        match_b;
  logic        buf_load;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [15:0] wr_word;

  ////////////////////////////////////////////////////////////////////////////
  // Event inputs

  tmr_sync u_sync_pin (
    .clock (clock),
    .nrst  (nrst),
    .raw   (capture_pin),
    .lvl   (pin_lvl)
  );

  tmr_sync u_sync_cmp (
    .clock (clock),
    .nrst  (nrst),
    .raw   (comparator_output),
    .lvl   (cmp_lvl)
  );

  assign src_lvl = s_reg.src_cmp ? cmp_lvl : pin_lvl;
  // Capture is off while the capture register serves as top
  assign cap_event = (src_lvl != s_reg.lvl_prev)
                   && (src_lvl == s_reg.edge_rise) && !cap_top;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  always_comb
  begin
    is_fast  = 1'b0;
    is_pc    = 1'b0;
    is_pfc   = 1'b0;
    cap_top  = 1'b0;
    tog_a_ok = 1'b1;
    top_val  = `TMR_MAX;
    fix_mask = `TMR_MAX;
    case (s_reg.mode)
      tmr_pkg::TMR_M_PC8:
      begin
        is_pc    = 1'b1;
        top_val  = `TMR_TOP8;
        fix_mask = `TMR_TOP8;
      end
      tmr_pkg::TMR_M_PC9:
      begin
        is_pc    = 1'b1;
        top_val  = `TMR_TOP9;
        fix_mask = `TMR_TOP9;
      end
      tmr_pkg::TMR_M_PC10:
      begin
        is_pc    = 1'b1;
        top_val  = `TMR_TOP10;
        fix_mask = `TMR_TOP10;
      end
      tmr_pkg::TMR_M_CTC_A:
        top_val = s_reg.cmpa;
      tmr_pkg::TMR_M_FAST8:
      begin
        is_fast  = 1'b1;
        top_val  = `TMR_TOP8;
        fix_mask = `TMR_TOP8;
      end
      tmr_pkg::TMR_M_FAST9:
      begin
        is_fast  = 1'b1;
        top_val  = `TMR_TOP9;
        fix_mask = `TMR_TOP9;
      end
      tmr_pkg::TMR_M_FAST10:
      begin
        is_fast  = 1'b1;
        top_val  = `TMR_TOP10;
        fix_mask = `TMR_TOP10;
      end
      tmr_pkg::TMR_M_PFC_C:
      begin
        is_pc   = 1'b1;
        is_pfc  = 1'b1;
        cap_top = 1'b1;
        top_val = s_reg.cap;
      end
      tmr_pkg::TMR_M_PFC_A:
      begin
        is_pc   = 1'b1;
        is_pfc  = 1'b1;
        top_val = s_reg.cmpa;
      end
      tmr_pkg::TMR_M_PC_C:
      begin
        is_pc   = 1'b1;
        cap_top = 1'b1;
        top_val = s_reg.cap;
      end
      tmr_pkg::TMR_M_PC_A:
      begin
        is_pc   = 1'b1;
        top_val = s_reg.cmpa;
      end
      tmr_pkg::TMR_M_CTC_C:
      begin
        cap_top = 1'b1;
        top_val = s_reg.cap;
      end
      // Register tops run any width from 2 to 16 bits
      tmr_pkg::TMR_M_FAST_C:
      begin
        is_fast = 1'b1;
        cap_top = 1'b1;
        top_val = s_reg.cap;
      end
      tmr_pkg::TMR_M_FAST_A:
      begin
        is_fast = 1'b1;
        top_val = s_reg.cmpa;
      end
      default:
        top_val = `TMR_MAX;
    endcase
    if (is_fast)
      tog_a_ok = (s_reg.mode == tmr_pkg::TMR_M_FAST_C)
              || (s_reg.mode == tmr_pkg::TMR_M_FAST_A);
    else if (is_pc)
      tog_a_ok = (s_reg.mode == tmr_pkg::TMR_M_PFC_A)
              || (s_reg.mode == tmr_pkg::TMR_M_PC_A);
  end

  assign buffered = is_fast || is_pc;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and compare

  always_comb
  begin
    case (s_reg.clk_sel)
      tmr_pkg::TMR_CS_DIV1:    div_mask = `TMR_DIV_M1;
      tmr_pkg::TMR_CS_DIV8:    div_mask = `TMR_DIV_M8;
      tmr_pkg::TMR_CS_DIV64:   div_mask = `TMR_DIV_M64;
      tmr_pkg::TMR_CS_DIV256:  div_mask = `TMR_DIV_M256;
      default:                 div_mask = `TMR_DIV_M1024;
    endcase
  end

  assign tick = (s_reg.clk_sel != tmr_pkg::TMR_CS_STOP)
             && (s_reg.clk_sel < tmr_pkg::TMR_CS_RSV6)
             && ((s_reg.div & div_mask) == div_mask);
  // Equality match: a top written below the count is passed by, so the
  // counter wraps through the maximum before it meets top again
  assign at_top  = (s_reg.cnt == top_val);
  assign at_bot  = (s_reg.cnt == `TMR_BOTTOM);
  assign match_a = (s_reg.cnt == s_reg.cmpa);
  assign match_b = (s_reg.cnt == s_reg.cmpb);
  // A compare above top never matches; software keeps top high enough
  assign buf_load = tick && (is_pfc ? at_bot : at_top);
  assign wr_word  = {s_reg.temp, bus.wdata};

  ////////////////////////////////////////////////////////////////////////////
  // Waveform step for one channel

  function automatic logic wave_step(
    input logic       out,
    input logic [1:0] act,
    input logic       hit,
    input logic       eq_top,
    input logic       tog_ok
  );
    wave_step = out;
    if (act == 2'b01)
    begin
      if (hit && tog_ok)
        wave_step = ~out;
    end
    else if (act[1] && is_fast)
    begin
      if (at_top)
        wave_step = ~act[0];
      else if (hit && !eq_top)
        wave_step = act[0];
    end
    else if (act[1] && is_pc)
    begin
      if (hit)
        wave_step = s_reg.down ? ~act[0] : act[0];
    end
    else if (act[1])
    begin
      if (hit)
        wave_step = act[0];
    end
  endfunction : wave_step

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_next          = s_reg;
    s_next.rdata    = 8'h00;
    s_next.div      = s_reg.div + 10'h001;
    s_next.lvl_prev = src_lvl;
    flag_set        = 4'h0;
    flag_clr        = 4'h0;

    if (cap_event)
    begin
      s_next.cap                = s_reg.cnt;
      flag_set[`TMR_ST_CAP]     = 1'b1;
    end

    if (tick)
    begin
      s_next.out_a = wave_step(s_reg.out_a, s_reg.act_a, match_a,
                               s_reg.cmpa == top_val, tog_a_ok);
      s_next.out_b = wave_step(s_reg.out_b, s_reg.act_b, match_b,
                               s_reg.cmpb == top_val, !buffered);
      flag_set[`TMR_ST_CMPA] = match_a;
      flag_set[`TMR_ST_CMPB] = match_b;
      if (cap_top && at_top)
        flag_set[`TMR_ST_CAP] = 1'b1;
      if (is_fast)
        flag_set[`TMR_ST_OVF] = at_top;
      else if (is_pc)
        flag_set[`TMR_ST_OVF] = at_bot;
      else
        flag_set[`TMR_ST_OVF] = (s_reg.cnt == `TMR_MAX);
      if (is_pc)
      begin
        if (!s_reg.down && at_top)
        begin
          s_next.down = 1'b1;
          s_next.cnt  = s_reg.cnt - 16'h0001;
        end
        else if (s_reg.down && at_bot)
        begin
          s_next.down = 1'b0;
          s_next.cnt  = s_reg.cnt + 16'h0001;
        end
        else if (s_reg.down)
          s_next.cnt = s_reg.cnt - 16'h0001;
        else
          s_next.cnt = s_reg.cnt + 16'h0001;
      end
      else if (at_top)
        s_next.cnt = `TMR_BOTTOM;
      else
        s_next.cnt = s_reg.cnt + 16'h0001;
    end
    if (buf_load)
    begin
      s_next.cmpa = s_reg.cmpa_buf;
      s_next.cmpb = s_reg.cmpb_buf;
    end

    if (bus.wr)
    begin
      if (bus.addr == `TMR_ADDR_CTRL_A)
      begin
        s_next.act_a     = bus.wdata[`TMR_ACT_A_LSB +: 2];
        s_next.act_b     = bus.wdata[`TMR_ACT_B_LSB +: 2];
        s_next.mode      = tmr_pkg::tmr_mode_e'(
          {s_reg.mode[3:2], bus.wdata[`TMR_WGM_LO_LSB +: 2]});
      end
      else if (bus.addr == `TMR_ADDR_CTRL_B)
      begin
        s_next.edge_rise = bus.wdata[`TMR_EDGE_BIT];
        s_next.src_cmp   = bus.wdata[`TMR_SRC_BIT];
        s_next.mode      = tmr_pkg::tmr_mode_e'(
          {bus.wdata[`TMR_WGM_HI_LSB +: 2], s_reg.mode[1:0]});
        s_next.clk_sel   = tmr_pkg::tmr_clk_e'(bus.wdata[`TMR_CS_LSB +: 3]);
      end
      else if (bus.addr == `TMR_ADDR_CNT_L)
        s_next.cnt = wr_word;
      else if (bus.addr == `TMR_ADDR_CMPA_L)
      begin
        s_next.cmpa_buf = wr_word & fix_mask;
        if (!buffered)
          s_next.cmpa = wr_word & fix_mask;
      end
      else if (bus.addr == `TMR_ADDR_CMPB_L)
      begin
        s_next.cmpb_buf = wr_word & fix_mask;
        if (!buffered)
          s_next.cmpb = wr_word & fix_mask;
      end
      else if (bus.addr == `TMR_ADDR_CAP_L)
      begin
        if (cap_top)
          s_next.cap = wr_word;
      end
      else if (bus.addr == `TMR_ADDR_IRQ_CLR)
        flag_clr = bus.wdata[3:0];
      else if (bus.addr == `TMR_ADDR_IRQ_EN)
        s_next.en = bus.wdata[3:0];
      else if (bus.addr == `TMR_ADDR_CNT_H || bus.addr == `TMR_ADDR_CMPA_H
            || bus.addr == `TMR_ADDR_CMPB_H || bus.addr == `TMR_ADDR_CAP_H)
        s_next.temp = bus.wdata;
    end

    if (bus.rd)
    begin
      if (bus.addr == `TMR_ADDR_CTRL_A)
        s_next.rdata = {s_reg.act_a, s_reg.act_b, 2'h0, s_reg.mode[1:0]};
      else if (bus.addr == `TMR_ADDR_CTRL_B)
        s_next.rdata = {1'b0, s_reg.edge_rise, s_reg.src_cmp,
                        s_reg.mode[3:2], s_reg.clk_sel};
      else if (bus.addr == `TMR_ADDR_CNT_L)
      begin
        s_next.rdata = s_reg.cnt[7:0];
        s_next.temp  = s_reg.cnt[15:8];
      end
      else if (bus.addr == `TMR_ADDR_CAP_L)
      begin
        s_next.rdata = s_reg.cap[7:0];
        s_next.temp  = s_reg.cap[15:8];
      end
      else if (bus.addr == `TMR_ADDR_CNT_H || bus.addr == `TMR_ADDR_CAP_H)
        s_next.rdata = s_reg.temp;
      else if (bus.addr == `TMR_ADDR_CMPA_L)
        s_next.rdata = s_reg.cmpa_buf[7:0];
      else if (bus.addr == `TMR_ADDR_CMPA_H)
        s_next.rdata = s_reg.cmpa_buf[15:8];
      else if (bus.addr == `TMR_ADDR_CMPB_L)
        s_next.rdata = s_reg.cmpb_buf[7:0];
      else if (bus.addr == `TMR_ADDR_CMPB_H)
        s_next.rdata = s_reg.cmpb_buf[15:8];
      else if (bus.addr == `TMR_ADDR_IRQ_STAT)
        s_next.rdata = {4'h0, s_reg.stat};
      else if (bus.addr == `TMR_ADDR_IRQ_EN)
        s_next.rdata = {4'h0, s_reg.en};
    end

    if (capture_ack)
      flag_clr[`TMR_ST_CAP] = 1'b1;
    // A set in the clearing cycle survives
    s_next.stat = (s_reg.stat & ~flag_clr) | flag_set;
    s_next.irq  = |(s_next.stat & s_next.en);
    s_next.oe_a = (s_reg.act_a != 2'b00)
               && !(s_reg.act_a == 2'b01 && !tog_a_ok);
    s_next.oe_b = (s_reg.act_b != 2'b00)
               && !(s_reg.act_b == 2'b01 && buffered);
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      s_reg <= `TMR_RST_STATE;
    else
      s_reg <= s_next;
  end

  assign rdata      = s_reg.rdata;
  assign irq        = s_reg.irq;
  assign wave_out_a = s_reg.out_a;
  assign wave_oe_a  = s_reg.oe_a;
  assign wave_out_b = s_reg.out_b;
  assign wave_oe_b  = s_reg.oe_b;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_low_read;
    bus.rd && bus.addr == `TMR_ADDR_CAP_L;
  endsequence
  sequence s_high_read;
    bus.rd && bus.addr == `TMR_ADDR_CAP_H;
  endsequence

  a_capture_copy: assert property (
    cap_event && !(bus.wr && bus.addr == `TMR_ADDR_CAP_L)
      |=> s_reg.cap == $past(s_reg.cnt))
    else $error("capture did not copy the count");
  a_capture_flag: assert property (
    cap_event |=> s_reg.stat[`TMR_ST_CAP])
    else $error("capture flag not set with capture");
  a_capture_irq: assert property (
    s_reg.stat[`TMR_ST_CAP] && s_reg.en[`TMR_ST_CAP] |-> irq)
    else $error("capture interrupt missing");
  a_ack_clears: assert property (
    capture_ack && !flag_set[`TMR_ST_CAP] |=> !s_reg.stat[`TMR_ST_CAP])
    else $error("acknowledge left capture flag set");
  a_temp_pair: assert property (
    s_low_read ##1 s_high_read |=> rdata == $past(s_reg.cap[15:8], 2))
    else $error("high byte read did not return latched byte");
  a_cap_guard: assert property (
    bus.wr && bus.addr == `TMR_ADDR_CAP_L && !cap_top && !cap_event
      |=> $stable(s_reg.cap))
    else $error("capture register written outside top modes");
  a_fast_wrap: assert property (
    tick && is_fast && at_top && !bus.wr |=> s_reg.cnt == `TMR_BOTTOM)
    else $error("fast mode did not clear after top");
  a_min_res: assert property (
    tick && s_reg.mode == tmr_pkg::TMR_M_FAST_C && s_reg.cap == 16'h0003
      && s_reg.cnt == 16'h0003 && !bus.wr |=> s_reg.cnt == `TMR_BOTTOM)
    else $error("two-bit top not honoured");
  a_fast_ovf: assert property (
    tick && is_fast && at_top |=> s_reg.stat[`TMR_ST_OVF])
    else $error("overflow flag missing at top");
  a_cmp_flag: assert property (
    tick && match_b |=> s_reg.stat[`TMR_ST_CMPB])
    else $error("compare flag missing on match");
  a_fixed_mask: assert property (
    bus.wr && bus.addr == `TMR_ADDR_CMPA_L
      |=> (s_reg.cmpa_buf & ~$past(fix_mask)) == `TMR_BOTTOM)
    else $error("compare bits above resolution kept");
  a_cap_direct: assert property (
    bus.wr && bus.addr == `TMR_ADDR_CAP_L && cap_top
      |=> s_reg.cap == $past(wr_word))
    else $error("capture top write not immediate");
  a_cmpa_buffer: assert property (
    bus.wr && bus.addr == `TMR_ADDR_CMPA_L && buffered && !buf_load
      |=> $stable(s_reg.cmpa))
    else $error("buffered compare changed on write");
  a_fast_bottom: assert property (
    tick && is_fast && s_reg.act_a == 2'b10 && at_top |=> wave_out_a)
    else $error("output not set at bottom");
  a_top_ignore: assert property (
    tick && is_fast && s_reg.act_b == 2'b11 && s_reg.cmpb == top_val
      && at_top |=> !wave_out_b)
    else $error("match at top not ignored");
  a_pc_up_clear: assert property (
    tick && is_pc && !s_reg.down && match_a && s_reg.act_a == 2'b10
      |=> !wave_out_a)
    else $error("phase-correct up match did not clear");
  a_edge_pick: assert property (
    cap_event |-> (s_reg.edge_rise ? $rose(src_lvl) : $fell(src_lvl)))
    else $error("capture on wrong edge");

endmodule : tmr_core
`default_nettype wire

// ==== src/tmr_sync.sv ====
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"

module tmr_sync (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic raw,
  output logic      lvl
);

  tmr_pkg::tmr_sync_s s_reg;
  tmr_pkg::tmr_sync_s s_next;

  // First flop feeds only the second; the level moves once 2 and 3 agree
  always_comb
  begin
    s_next    = s_reg;
    s_next.ff = {s_reg.ff[1:0], raw};
    if (s_reg.ff[1] == s_reg.ff[2])
      s_next.lvl = s_reg.ff[2];
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      s_reg <= `TMR_RST_SYNC;
    else
      s_reg <= s_next;
  end

  assign lvl = s_reg.lvl;

endmodule : tmr_sync
`default_nettype wire

// ==== test/timer16_capture_fast_pwm_tb.sv ====
// Self-checking bench of the 16-bit timer through its byte bus
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"

module timer16_capture_fast_pwm_tb;
  logic             clock = 1'b0;
  logic             nrst = 1'b0;
  tmr_pkg::tmr_bus_s bus = '0;
  logic [7:0]       rdata, b;
  logic [15:0]      v;
  logic             pin_req = 1'b0, cmp_req = 1'b0, capture_ack = 1'b0;
  logic             irq, wave_out_a, wave_oe_a, wave_out_b, wave_oe_b;
  logic             capture_pin, comparator_output;
  int               fails = 0, check_count = 0;
  // Action/mode pairs: ctrl_a, ctrl_b, expected enable of output A
  logic [16:0]      oe_tab [6] = '{{16'h0219, 1'b0}, {16'h4219, 1'b1},
    {16'h8219, 1'b1}, {16'hC219, 1'b1}, {16'h4109, 1'b0}, {16'h8109, 1'b1}};

  always #10 clock = ~clock;

  tmr_evt_src src (.clock(clock), .pin_req(pin_req), .cmp_req(cmp_req),
    .capture_pin(capture_pin), .comparator_output(comparator_output));

  tmr_core dut (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .capture_ack(capture_ack), .irq(irq), .wave_out_a(wave_out_a),
    .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask : rd

  // High byte first on write, low byte first on read
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(a + 4'h1, d[15:8]);
    wr(a, d[7:0]);
  endtask : wr16

  // Two reads back to back, as a byte-wide CPU would issue them
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.addr <= a + 4'h1;
    @(posedge clock);
    d[7:0] = rdata;
    bus.rd <= 1'b0;
    @(posedge clock);
    d[15:8] = rdata;
  endtask : rd16

  task automatic give_verdict;
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    fails++;
    give_verdict;
  end

  initial
  begin
    cyc(3);
    nrst <= 1'b1;
    rd(`TMR_ADDR_IRQ_STAT, b);
    chk("status", 16'h0000, b);
    // Counter frozen so captured values are known
    wr(`TMR_ADDR_CTRL_B, 8'h40);
    wr16(`TMR_ADDR_CNT_L, 16'h1234);
    pin_req <= 1'b1;
    cyc(8);
    rd(`TMR_ADDR_IRQ_STAT, b);
    chk("capture flag", 16'h0008, b);
    chk("irq masked", 16'h0000, irq);
    wr(`TMR_ADDR_IRQ_EN, 8'h08);
    cyc(1);
    chk("irq enabled", 16'h0001, irq);
    wr16(`TMR_ADDR_CNT_L, 16'h5678);
    rd16(`TMR_ADDR_CAP_L, v);
    chk("capture value", 16'h1234, v);
    capture_ack <= 1'b1;
    cyc(1);
    capture_ack <= 1'b0;
    cyc(1);
    chk("irq after ack", 16'h0000, irq);
    wr(`TMR_ADDR_CTRL_B, 8'h00);
    pin_req <= 1'b0;
    cyc(8);
    wr(`TMR_ADDR_IRQ_CLR, 8'h0F);
    cyc(1);
    chk("irq after clear", 16'h0000, irq);
    wr16(`TMR_ADDR_CNT_L, 16'h9ABC);
    pin_req <= 1'b1;
    cyc(8);
    rd(`TMR_ADDR_IRQ_STAT, b);
    chk("rise ignored", 16'h0000, b);
    rd16(`TMR_ADDR_CAP_L, v);
    chk("falling capture", 16'h5678, v);
    wr(`TMR_ADDR_CTRL_B, 8'h60);
    cmp_req <= 1'b1;
    cyc(8);
    rd16(`TMR_ADDR_CAP_L, v);
    chk("comparator capture", 16'h9ABC, v);
    wr16(`TMR_ADDR_CAP_L, 16'h0003);
    rd16(`TMR_ADDR_CAP_L, v);
    chk("capture write refused", 16'h9ABC, v);
    // Mode 14 with the smallest top the resolution allows
    wr(`TMR_ADDR_CTRL_A, 8'h02);
    wr(`TMR_ADDR_CTRL_B, 8'h18);
    wr16(`TMR_ADDR_CAP_L, 16'h0003);
    rd16(`TMR_ADDR_CAP_L, v);
    chk("capture as top", 16'h0003, v);
    wr16(`TMR_ADDR_CNT_L, 16'h0000);
    wr(`TMR_ADDR_IRQ_CLR, 8'h0F);
    wr(`TMR_ADDR_CTRL_B, 8'h19);
    cyc(12);
    rd(`TMR_ADDR_IRQ_STAT, b);
    chk("flags at top", 16'h000F, b);
    foreach (oe_tab[i])
    begin
      wr(`TMR_ADDR_CTRL_A, oe_tab[i][16:9]);
      wr(`TMR_ADDR_CTRL_B, oe_tab[i][8:1]);
      cyc(4);
      chk("output a enable", {15'h0, oe_tab[i][0]}, wave_oe_a);
    end
    wr(`TMR_ADDR_CTRL_B, 8'h08);
    wr16(`TMR_ADDR_CMPA_L, 16'h1234);
    rd16(`TMR_ADDR_CMPA_L, v);
    chk("compare a masked", 16'h0034, v);
    wr16(`TMR_ADDR_CMPB_L, 16'hFFFF);
    rd16(`TMR_ADDR_CMPB_L, v);
    chk("compare b masked", 16'h00FF, v);
    // Fast 8-bit with compares 0x34 and 0xFF waiting in the buffers
    wr(`TMR_ADDR_CTRL_A, 8'hB1);
    wr16(`TMR_ADDR_CNT_L, 16'h0000);
    wr(`TMR_ADDR_CTRL_B, 8'h09);
    wr(`TMR_ADDR_IRQ_CLR, 8'h0F);
    cyc(80);
    rd(`TMR_ADDR_IRQ_STAT, b);
    chk("no early compare", 16'h0000, b);
    cyc(195);
    chk("output a at bottom", 16'h0001, wave_out_a);
    cyc(100);
    chk("output a on match", 16'h0000, wave_out_a);
    cyc(160);
    chk("output a again", 16'h0001, wave_out_a);
    chk("output b top match", 16'h0000, wave_out_b);
    chk("output b enable", 16'h0001, wave_oe_b);
    // Phase correct 8-bit: clear on the way up, set on the way down
    wr(`TMR_ADDR_CTRL_B, 8'h00);
    wr16(`TMR_ADDR_CNT_L, 16'h0000);
    wr(`TMR_ADDR_CTRL_B, 8'h01);
    cyc(300);
    chk("pc up match", 16'h0000, wave_out_a);
    cyc(200);
    chk("pc down match", 16'h0001, wave_out_a);
    cyc(120);
    chk("pc next up match", 16'h0000, wave_out_a);
    rd(4'hF, b);
    chk("unmapped read", 16'h0000, b);
    give_verdict;
  end
endmodule : timer16_capture_fast_pwm_tb

`default_nettype wire

// ==== test/tmr_evt_src.sv ====
// Model of the external event sources feeding the capture inputs
`timescale 1ns/1ps
`default_nettype none

module tmr_evt_src (
  input  wire logic clock,
  input  wire logic pin_req,
  input  wire logic cmp_req,
  output logic      capture_pin,
  output logic      comparator_output
);
  ////////////////////////////////////////////////////////////////////////
  // Levels move only after an edge; the design must synchronise them
  always_ff @(posedge clock)
  begin
    capture_pin       <= pin_req;
    comparator_output <= cmp_req;
  end
endmodule : tmr_evt_src

`default_nettype wire
